// >>> rpdm_mapper.sv
// Receive process-data mapper: eight mappings, sync/async commit, target stream.
// Assumes frame, sync, restart and NMT inputs come from logic on mclk_in.
`timescale 1ns/10ps

// Summary of operation
// - Frames are used only while Operational; configuration happens in Pre-Operational.
// - Eight independent mappings, each message carries at most eight payload bytes.
// - Short frames are accepted; only bytes covered by active entries matter.
// - Mapping N communication parameters sit at consecutive indices from 1400h.
// - Mappings one to four derive their identifier; only the valid bit is writable.
// - Mappings five to eight take written identifier and valid bit.
// - Identifier writes store at once; the filter uses them after restart.
// - Default identifiers are node id plus 200h, 300h, 400h and 500h.
// - Types 00h to F0h buffer data and commit at the next SYNC.
// - Types FEh and FFh commit data as soon as the frame arrives.
// - The count states how many leading entries are active.
// - A count of zero disables the mapping entirely.
// - Entries are consumed in ascending order without gaps.
// - An entry packs index, subindex and bit length, high to low.
// - Payload is sliced consecutively from byte zero, entry by entry.
// - Dummy indices 0002h to 0007h consume bits but write nothing.
// - Frames hold payload only; meaning comes from the stored mapping.
// - Configuration writes while Operational are refused with 08000022h.
// - Mappings longer than eight bytes are refused with 06040042h.
module rpdm_mapper (
    // Clock and reset
    input  wire logic                    mclk_in,
    input  wire logic                    rst_in,
    // Node state and events
    input  wire logic [6:0]              node_id_in,
    input  wire logic                    nmt_oper_in,
    input  wire logic                    restart_in,
    input  wire logic                    sync_in,
    input  wire rpdm_pkg::rpdm_frame_type frame_in,
    // Register port
    input  wire rpdm_pkg::rpdm_bus_type  bus_in,
    output logic [31:0]                  rdata_out,
    // Target write stream
    output logic                         tgt_valid_out,
    output rpdm_pkg::rpdm_tgt_type       tgt_out
);
    import rpdm_pkg::*;

    typedef struct packed {
        logic [NMAP-1:0][31:0]           cob;
        logic [NMAP-1:0][31:0]           cob_act;
        logic [NMAP-1:0][7:0]            ttype;
        logic [NMAP-1:0][3:0]            cnt;
        rpdm_ent_type [NMAP-1:0][NENT-1:0] ent;
        logic [NMAP-1:0][63:0]           pbuf;
        logic [NMAP-1:0]                 pend;
        logic [NMAP-1:0]                 armed;
        logic [31:0]                     abort;
        logic [31:0]                     rdata;
        rpdm_fsm_type                    state;
        logic [2:0]                      cur;
        logic [3:0]                      ei;
        logic [9:0]                      bitp;
        logic [63:0]                     work;
        logic                            tgt_v;
        rpdm_tgt_type                    tgt;
        logic [6:0]                      node_s1;
        logic [6:0]                      node_s2;
        logic [1:0]                      init;
    } rpdm_st_type;

    rpdm_st_type              q;
    rpdm_st_type              d;
    logic [NMAP-1:0][31:0]    cobv;
    logic                     hit;
    logic [2:0]               hsel;
    logic [2:0]               asel;
    logic [2:0]               wm;
    logic [63:0]              masked;
    rpdm_ent_type [NENT-1:0]  tmp;
    rpdm_ent_type             re;
    logic                     run_act;
    logic [3:0]               lim;
    logic [63:0]              slice;

    function automatic logic [9:0] len_sum(input rpdm_ent_type [NENT-1:0] e, input logic [3:0] n);
        logic [9:0] s;
        s = '0;
        for (int i = 0; i < NENT; i++) begin
            if (i < n) begin
                s = s + {2'h0, e[i].len};
            end
        end
        return s;
    endfunction

    function automatic logic is_dummy(input logic [15:0] idx);
        return (idx >= DUMMY_MIN) && (idx <= DUMMY_MAX);
    endfunction

    always_comb begin
        d       = q;
        hit     = 1'b0;
        hsel    = '0;
        asel    = '0;
        masked  = '0;
        tmp     = '0;
        lim     = '0;
        slice   = '0;
        wm      = bus_in.addr[6:4];
        re      = q.ent[q.cur][q.ei[2:0]];
        run_act = (q.state == RPDM_RUN) && (q.ei < q.cnt[q.cur]);
        d.tgt_v = 1'b0;
        d.rdata = '0;
        d.node_s1 = node_id_in;
        d.node_s2 = q.node_s1;

        // Identifier view: fixed mappings derive the id from the node id
        for (int m = 0; m < NMAP; m++) begin
            if (m < 4) begin
                cobv[m] = {q.cob[m][COB_VALID_BIT], 20'h0_0000, COB_BASE[m[1:0]] + {4'h0, q.node_s2}};
            end else begin
                cobv[m] = q.cob[m];
            end
        end

        // Filter takes new identifiers at restart and once, three cycles after reset
        if (q.init != 2'h0) begin
            d.init = q.init - 2'h1;
        end
        if (restart_in || (q.init == 2'h1)) begin
            d.cob_act = cobv;
        end

        // Sync arms buffered synchronous data
        if (sync_in) begin
            for (int m = 0; m < NMAP; m++) begin
                if (q.pend[m] && (q.ttype[m] <= TT_SYNC_MAX)) begin
                    d.armed[m] = 1'b1;
                end
            end
        end

        // Unpack one armed mapping, one entry per cycle
        for (int m = NMAP - 1; m >= 0; m--) begin
            if (q.armed[m]) begin
                asel = m[2:0];
            end
        end
        case (q.state)
            RPDM_IDLE: begin
                if (|q.armed) begin
                    d.cur          = asel;
                    d.work         = q.pbuf[asel];
                    d.pend[asel]   = 1'b0;
                    d.armed[asel]  = 1'b0;
                    d.ei           = '0;
                    d.bitp         = '0;
                    d.state        = RPDM_RUN;
                end
            end
            RPDM_RUN: begin
                if (!run_act) begin
                    d.state = RPDM_IDLE;
                end else begin
                    d.ei   = q.ei + 4'h1;
                    d.bitp = q.bitp + {2'h0, re.len};
                    if (!is_dummy(re.index)) begin
                        d.tgt_v = 1'b1;
                    end
                    d.tgt.ent  = re;
                    // Wide slices are cut to the 32-bit target word
                    slice      = (q.work >> q.bitp) & ((re.len >= 8'h20) ? 64'hFFFF_FFFF
                                 : ((64'h1 << re.len) - 64'h1));
                    d.tgt.data = slice[31:0];
                end
            end
            default: begin
                d.state = RPDM_IDLE;
            end
        endcase

        // Frame acceptance; a new frame wins over a commit taken this cycle
        for (int m = NMAP - 1; m >= 0; m--) begin
            if (frame_in.valid && nmt_oper_in && !q.cob_act[m][COB_VALID_BIT]
                && (frame_in.id == q.cob_act[m][10:0]) && (q.cnt[m] != 4'h0)) begin
                hit  = 1'b1;
                hsel = m[2:0];
            end
        end
        for (int b = 0; b < 8; b++) begin
            masked[b*8 +: 8] = (b < frame_in.dlc) ? frame_in.data[b*8 +: 8] : 8'h00;
        end
        if (hit) begin
            d.pbuf[hsel]  = masked;
            d.pend[hsel]  = 1'b1;
            d.armed[hsel] = (q.ttype[hsel] > TT_RSV_MAX);
        end

        // Register writes
        tmp = q.ent[wm];
        tmp[bus_in.addr[2:0]] = bus_in.wdata;
        lim = ({1'b0, bus_in.addr[2:0]} + 4'h1 > q.cnt[wm]) ? {1'b0, bus_in.addr[2:0]} + 4'h1 : q.cnt[wm];
        if (bus_in.wr) begin
            if (bus_in.addr == ADDR_ABORT) begin
                d.abort = '0;
            end else if (!bus_in.addr[7]) begin
                if (nmt_oper_in) begin
                    d.abort = ABORT_STATE;
                end else if (bus_in.addr[3]) begin
                    if (len_sum(tmp, lim) > PAYLOAD_BITS) begin
                        d.abort = ABORT_LEN;
                    end else begin
                        d.ent[wm][bus_in.addr[2:0]] = bus_in.wdata;
                    end
                end else begin
                    case (bus_in.addr[3:0])
                        SEL_COB: begin
                            if (wm < 3'h4) begin
                                d.cob[wm][COB_VALID_BIT] = bus_in.wdata[COB_VALID_BIT];
                            end else begin
                                d.cob[wm] = {bus_in.wdata[COB_VALID_BIT], 20'h0_0000, bus_in.wdata[10:0]};
                            end
                        end
                        SEL_TT: begin
                            if ((bus_in.wdata[7:0] > TT_SYNC_MAX) && (bus_in.wdata[7:0] <= TT_RSV_MAX)) begin
                                d.abort = ABORT_VALUE;
                            end else begin
                                d.ttype[wm] = bus_in.wdata[7:0];
                            end
                        end
                        SEL_CNT: begin
                            if ((bus_in.wdata[7:0] > NENT_MAX)
                                || (len_sum(q.ent[wm], bus_in.wdata[3:0]) > PAYLOAD_BITS)) begin
                                d.abort = ABORT_LEN;
                            end else begin
                                d.cnt[wm] = bus_in.wdata[3:0];
                            end
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // Register reads, data in the following cycle only
        if (bus_in.rd) begin
            if (bus_in.addr == ADDR_ABORT) begin
                d.rdata = q.abort;
            end else if (bus_in.addr == ADDR_STAT) begin
                d.rdata = {14'h0000, q.state, q.pend, q.armed};
            end else if (!bus_in.addr[7]) begin
                if (bus_in.addr[3]) begin
                    d.rdata = q.ent[wm][bus_in.addr[2:0]];
                end else begin
                    case (bus_in.addr[3:0])
                        SEL_COB: d.rdata = cobv[wm];
                        SEL_TT:  d.rdata = {24'h00_0000, q.ttype[wm]};
                        SEL_CNT: d.rdata = {28'h000_0000, q.cnt[wm]};
                        SEL_IDX: d.rdata = {COMM_IDX_BASE + {13'h0000, wm}, MAP_IDX_BASE + {13'h0000, wm}};
                        default: d.rdata = '0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            q         <= '0;
            q.ttype   <= {NMAP{TT_RST}};
            q.cob_act <= {NMAP{COB_RST_FREE}};
            q.init    <= INIT_CYCLES;
            for (int m = 4; m < NMAP; m++) begin
                q.cob[m] <= COB_RST_FREE;
            end
        end else begin
            q <= d;
        end
    end

    assign rdata_out     = q.rdata;
    assign tgt_valid_out = q.tgt_v;
    assign tgt_out       = q.tgt;

    default clocking @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    sequence seq_cfg_write;
        bus_in.wr && !bus_in.addr[7];
    endsequence

    sequence seq_async_hit0;
        hit && (hsel == 3'h0) && (q.ttype[0] > TT_RSV_MAX) && (q.state == RPDM_IDLE) && (q.armed == '0);
    endsequence

    sequence seq_run_start;
        (q.state == RPDM_IDLE) ##1 (q.state == RPDM_RUN);
    endsequence

    AST_NO_RX_PRE_OP: assert property ((frame_in.valid && !nmt_oper_in) |=> ((q.pend & ~$past(q.pend)) == '0))
        else $error("frame accepted outside Operational");
    AST_CFG_LOCKED: assert property ((seq_cfg_write ##0 nmt_oper_in) |=> (q.abort == ABORT_STATE) && $stable(q.cnt)
        && $stable(q.ent) && $stable(q.ttype))
        else $error("configuration changed while Operational");
    AST_SYNC_WAIT: assert property ($rose(q.armed[0]) |-> ($past(sync_in) || (q.ttype[0] > TT_RSV_MAX)))
        else $error("synchronous data armed without SYNC");
    AST_ASYNC_NOW: assert property (seq_async_hit0 |=> q.armed[0] ##1 (q.state == RPDM_RUN)[*1])
        else $error("asynchronous frame not committed at once");
    AST_NO_DUMMY_OUT: assert property (tgt_valid_out |-> !is_dummy(tgt_out.ent.index))
        else $error("dummy target written");
    AST_LEN_BOUND: assert property (len_sum(q.ent[0], q.cnt[0]) <= PAYLOAD_BITS)
        else $error("mapping exceeds eight bytes");
    AST_SLICE_STEP: assert property (run_act |=> (q.bitp == $past(q.bitp) + {2'h0, $past(re.len)})
        && (q.ei == $past(q.ei) + 4'h1))
        else $error("payload slice did not advance by entry length");
    AST_FIXED_ID: assert property (q.cob[0][30:0] == 31'h0000_0000 && q.cob[3][30:0] == 31'h0000_0000)
        else $error("fixed identifier overwritten");
    AST_ZERO_OFF: assert property ((q.cnt[1] == 4'h0 && !q.pend[1]) |=> !q.pend[1])
        else $error("disabled mapping took a frame");
    AST_ID_AT_RESTART: assert property ((!restart_in && q.init == 2'h0) |=> $stable(q.cob_act))
        else $error("filter identifier changed without restart");

    // Checks on acceptance, SYNC commit, slicing and configuration
    AST_HIT_GUARD: assert property (hit |-> nmt_oper_in && !q.cob_act[hsel][COB_VALID_BIT]
        && (q.cnt[hsel] != 4'h0) && (frame_in.id == q.cob_act[hsel][10:0]))
        else $error("frame taken by a closed mapping");
    AST_TGT_FROM_RUN: assert property (tgt_valid_out |-> $past(run_act))
        else $error("target written outside an active entry");
    AST_RUN_START: assert property (seq_run_start |-> (q.ei == 4'h0) && (q.bitp == 10'h000))
        else $error("unpacking did not start at entry one, bit zero");
    AST_TT_REFUSED: assert property ((seq_cfg_write ##0 (!nmt_oper_in && (bus_in.addr[3:0] == SEL_TT)
        && (bus_in.wdata[7:0] > TT_SYNC_MAX) && (bus_in.wdata[7:0] <= TT_RSV_MAX)))
        |=> (q.abort == ABORT_VALUE) && $stable(q.ttype))
        else $error("reserved transmission type stored");
    AST_RESTART_LOAD: assert property (restart_in |=> (q.cob_act == $past(cobv)))
        else $error("restart did not load stored identifiers");
    AST_SYNC_COMMIT: assert property ((sync_in && q.pend[1] && !q.armed[1] && (q.ttype[1] <= TT_SYNC_MAX)
        && !frame_in.valid) |=> q.armed[1])
        else $error("buffered data not released by SYNC");
    AST_CNT_MAX: assert property (q.cnt[2] <= NENT_MAX)
        else $error("entry count above eight");
    AST_LEN_BOUND4: assert property (len_sum(q.ent[4], q.cnt[4]) <= PAYLOAD_BITS)
        else $error("free mapping exceeds eight bytes");
endmodule

// >>> rpdm_pkg.sv
// Constants and types of the receive process-data mapper.
// Assumes one clock domain; frames arrive from a CAN controller on that clock.
package rpdm_pkg;
    localparam int NMAP = 8;
    localparam int NENT = 8;

    // Register map: addr[7]=0 per mapping, addr[6:4] mapping, addr[3:0] selector
    localparam logic [3:0]  SEL_COB    = 4'h0;
    localparam logic [3:0]  SEL_TT     = 4'h1;
    localparam logic [3:0]  SEL_CNT    = 4'h2;
    localparam logic [3:0]  SEL_IDX    = 4'h3;
    localparam logic [7:0]  ADDR_ABORT = 8'h80;
    localparam logic [7:0]  ADDR_STAT  = 8'h81;

    localparam int          COB_VALID_BIT = 31;
    localparam logic [10:0] COB_BASE [4]  = '{11'h200, 11'h300, 11'h400, 11'h500};
    localparam logic [15:0] COMM_IDX_BASE = 16'h1400;
    localparam logic [15:0] MAP_IDX_BASE  = 16'h1600;

    localparam logic [7:0]  TT_SYNC_MAX  = 8'hF0;
    localparam logic [7:0]  TT_RSV_MAX   = 8'hFD;
    localparam logic [15:0] DUMMY_MIN    = 16'h0002;
    localparam logic [15:0] DUMMY_MAX    = 16'h0007;
    localparam logic [9:0]  PAYLOAD_BITS = 10'h040;
    localparam logic [7:0]  NENT_MAX     = 8'h08;

    localparam logic [31:0] ABORT_STATE = 32'h0800_0022;
    localparam logic [31:0] ABORT_LEN   = 32'h0604_0042;
    localparam logic [31:0] ABORT_VALUE = 32'h0609_0031;

    // Values after reset
    localparam logic [31:0] COB_RST_FREE = 32'h8000_0000;
    localparam logic [7:0]  TT_RST       = 8'hFF;
    localparam logic [1:0]  INIT_CYCLES  = 2'h3;

    typedef enum logic [1:0] {
        RPDM_IDLE = 2'b00,
        RPDM_RUN  = 2'b01
    } rpdm_fsm_type;

    typedef struct packed {
        logic [15:0] index;
        logic [7:0]  sub;
        logic [7:0]  len;
    } rpdm_ent_type;

    typedef struct packed {
        logic        valid;
        logic [10:0] id;
        logic [3:0]  dlc;
        logic [63:0] data;
    } rpdm_frame_type;

    typedef struct packed {
        rpdm_ent_type ent;
        logic [31:0]  data;
    } rpdm_tgt_type;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [31:0] wdata;
    } rpdm_bus_type;
endpackage

// >>> rpdm_can_node.sv
// Far-side model: a CAN node that sends frames, SYNC and restart events.
// Assumes the mapper samples everything on the rising edge of mclk_in.
`timescale 1ns/10ps
module rpdm_can_node (
    // Clock
    input  wire logic                     mclk_in,
    // Bus events
    output rpdm_pkg::rpdm_frame_type      frame_out,
    output logic                          sync_out,
    output logic                          restart_out
);
    import rpdm_pkg::*;

    initial begin
        frame_out   = '0;
        sync_out    = 1'b0;
        restart_out = 1'b0;
    end

    // Payload only; fields scrambled once the frame has passed
    task automatic send(input logic [10:0] id, input logic [3:0] dlc, input logic [63:0] data);
        @(posedge mclk_in);
        frame_out <= '{1'b1, id, dlc, data};
        @(posedge mclk_in);
        frame_out <= '{1'b0, ~id, ~dlc, ~data};
    endtask

    task automatic pulse(input logic rst_sel);
        @(posedge mclk_in);
        if (rst_sel) restart_out <= 1'b1;
        else sync_out <= 1'b1;
        @(posedge mclk_in);
        restart_out <= 1'b0;
        sync_out    <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask
endmodule

// >>> test_rpdm_mapper.sv
// Self-checking bench of the receive process-data mapper.
// Assumes rpdm_pkg, rpdm_mapper and rpdm_can_node are compiled first.
`timescale 1ns/10ps
module test_rpdm_mapper;
    import rpdm_pkg::*;
    logic           mclk_in;
    logic           rst_in;
    logic           nmt_oper;
    logic           sync_s;
    logic           restart_s;
    logic [6:0]     node_id;
    logic [10:0]    nid;
    logic [63:0]    d;
    logic [31:0]    rdata;
    logic           tgt_valid;
    rpdm_frame_type frame_s;
    rpdm_bus_type   bus;
    rpdm_tgt_type   tgt;
    rpdm_tgt_type   tq[$];
    int             n_errors = 0;
    int             n_tests = 0;

    rpdm_mapper i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .node_id_in(node_id), .nmt_oper_in(nmt_oper),
        .restart_in(restart_s), .sync_in(sync_s), .frame_in(frame_s), .bus_in(bus), .rdata_out(rdata),
        .tgt_valid_out(tgt_valid), .tgt_out(tgt));
    rpdm_can_node i_node (.mclk_in(mclk_in), .frame_out(frame_s), .sync_out(sync_s),
        .restart_out(restart_s));

    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    always @(posedge mclk_in) begin
        if (tgt_valid === 1'b1) tq.push_back(tgt);
    end

    task automatic tally_and_finish;
        $display("errors=%0d tests=%0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk_in);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge mclk_in);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk_in);
        bus <= '{1'b0, 1'b1, a, 32'h0000_0000};
        @(posedge mclk_in);
        bus <= '0;
        #1 chk({32'h0, rdata}, {32'h0, e});
    endtask

    task automatic frm(input logic [10:0] id, input logic [3:0] dlc, input int n);
        tq.delete();
        i_node.send(id, dlc, d);
        repeat (12) @(posedge mclk_in);
        chk(tq.size(), n);
    endtask

    function automatic logic [7:0] ad(input int n, input logic [3:0] s);
        return {1'b0, n[2:0], s};
    endfunction

    // Expected payload slice, zero-extended
    function automatic logic [31:0] sl(input logic [63:0] v, input int off, input int len);
        logic [63:0] x;
        x = (v >> off) & ((64'h1 << len) - 64'h1);
        return x[31:0];
    endfunction

    initial begin
        #50000;
        n_errors++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'h65a6));
        node_id  = 7'($urandom);
        nid      = {4'h0, node_id};
        rst_in   = 1'b1;
        nmt_oper = 1'b0;
        bus      = '0;
        d        = {$urandom, $urandom};
        repeat (20) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rd(ad(0, SEL_TT), 32'h0000_00FF);
        for (int n = 0; n < 4; n++) rd(ad(n, SEL_COB), {21'h0, COB_BASE[n] + nid});
        rd(ad(4, SEL_COB), 32'h8000_0000);
        for (int n = 0; n < 8; n++) rd(ad(n, SEL_IDX), {16'h1400 + 16'(n), 16'h1600 + 16'(n)});
        rd(8'h90, 32'h0000_0000);
        // Configuration in Pre-Operational
        wr(ad(0, 4'h8), 32'h6040_0010);
        wr(ad(0, 4'h9), 32'h607A_0020);
        wr(ad(0, SEL_CNT), 32'h2);
        wr(ad(1, 4'h8), 32'h6041_0020);
        wr(ad(1, SEL_CNT), 32'h1);
        wr(ad(1, SEL_TT), $urandom % 241);
        wr(ad(2, 4'h8), 32'h0006_0010);
        wr(ad(2, 4'h9), 32'h6060_0008);
        wr(ad(2, SEL_CNT), 32'h2);
        wr(ad(4, SEL_COB), 32'h0000_0123);
        wr(ad(4, 4'h8), 32'h6070_0020);
        wr(ad(4, SEL_CNT), 32'h1);
        wr(ad(3, 4'h8), 32'h6000_0040);
        wr(ad(3, 4'h9), 32'h6001_0008);
        rd(ADDR_ABORT, 32'h0604_0042);
        rd(ad(3, 4'h9), 32'h0000_0000);
        wr(ADDR_ABORT, 32'h0);
        wr(ad(3, SEL_TT), 32'h0000_00F5);
        rd(ADDR_ABORT, 32'h0609_0031);
        rd(ad(3, SEL_TT), 32'h0000_00FF);
        wr(ADDR_ABORT, 32'h0);
        frm(11'h200 + nid, 4'h8, 0);
        @(posedge mclk_in);
        nmt_oper <= 1'b1;
        frm(11'h123, 4'h8, 0);
        i_node.pulse(1'b1);
        wr(ad(0, SEL_CNT), 32'h1);
        rd(ADDR_ABORT, 32'h0800_0022);
        rd(ad(0, SEL_CNT), 32'h2);
        d = {$urandom, $urandom};
        frm(11'h200 + nid, 4'h8, 2);
        chk(tq[0], {32'h6040_0010, sl(d, 0, 16)});
        chk(tq[1], {32'h607A_0020, sl(d, 16, 32)});
        d = {$urandom, $urandom};
        frm(11'h300 + nid, 4'h8, 0);
        rd(ADDR_STAT, 32'h0000_0200);
        i_node.pulse(1'b0);
        repeat (8) @(posedge mclk_in);
        chk(tq.size(), 1);
        chk(tq[0], {32'h6041_0020, sl(d, 0, 32)});
        frm(11'h400 + nid, 4'h3, 1);
        chk(tq[0], {32'h6060_0008, sl(d, 16, 8)});
        frm(11'h500 + nid, 4'h8, 0);
        frm(11'h123, 4'h8, 1);
        chk(tq[0], {32'h6070_0020, sl(d, 0, 32)});
        @(posedge mclk_in);
        nmt_oper <= 1'b0;
        wr(ad(0, SEL_COB), 32'hFFFF_FFFF);
        rd(ad(0, SEL_COB), {1'b1, 20'h0, 11'h200 + nid});
        i_node.pulse(1'b1);
        @(posedge mclk_in);
        nmt_oper <= 1'b1;
        frm(11'h200 + nid, 4'h8, 0);
        tally_and_finish();
    end
endmodule
